// [src/apsp_consts.svh]
// Constants for the addressable parallel slave port.
// Assumes inclusion by bare name from the port's design files.
`ifndef APSP_CONSTS_SVH
`define APSP_CONSTS_SVH
`define APSP_CTL_ON 15
`define APSP_CTL_CSP 3
`define APSP_CTL_WRITE_STROBE_POLARITY 1
`define APSP_CTL_READ_STROBE_POLARITY 0
`define APSP_MODE_IRQ_HI 14
`define APSP_MODE_IRQ_LO 13
`define APSP_MODE_SEL_HI 9
`define APSP_MODE_SEL_LO 8
`define APSP_MODE_ADDRESSED 2'h0
`define APSP_LAST_BYTE 2'h3
`define APSP_BYTES 4
`define APSP_OUT_EMPTY_RST 4'hF
`define APSP_IN_FULL_RST 4'h0
`endif

// [src/apsp_pkg.sv]
// Types for the addressable parallel slave port.
// Assumes apsp_consts.svh is compiled alongside.
package apsp_pkg;
    typedef enum logic [1:0] {
        APSP_IRQ_NONE = 2'h0,
        APSP_IRQ_EVERY = 2'h1,
        APSP_IRQ_LAST = 2'h2,
        APSP_IRQ_RSVD = 2'h3
    } apsp_irq_mode_t;
    typedef enum logic [1:0] {
        APSP_IDLE = 2'h0,
        APSP_RD = 2'h1,
        APSP_WR = 2'h2
    } apsp_state_t;
endpackage

// [src/apsp_port.sv]
// Addressable buffered 8-bit parallel slave port.
// Assumes external strobes are asynchronous to clock and held for at least
// three clock periods; software reaches control and buffers through plain ports.
`include "apsp_consts.svh"

module apsp_port (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Configuration
    input wire logic [15:0] port_control_reg,
    input wire logic [15:0] port_mode_reg,
    input wire logic port_irq_enable,
    // Software side: output byte loads
    input wire logic sw_out_load,
    input wire logic [1:0] sw_out_sel,
    input wire logic [7:0] sw_out_data,
    // Software side: input byte reads, through a two-entry buffer
    input wire logic sw_in_req,
    input wire logic [1:0] sw_in_sel,
    output logic sw_in_req_ready,
    output logic sw_in_valid,
    input wire logic sw_in_ready,
    output logic [7:0] sw_in_data,
    // Software side: interrupt flag clear
    input wire logic port_irq_clear,
    // Status
    output logic [3:0] per_buffer_out_empty,
    output logic all_out_empty,
    output logic out_underflow,
    output logic [3:0] per_buffer_in_full,
    output logic all_in_full,
    output logic in_overflow,
    output logic port_irq_flag,
    output logic port_irq,
    output logic [31:0] output_buffer_reg,
    output logic [31:0] input_buffer_reg,
    // External parallel pins
    input wire logic chip_select_pin,
    input wire logic read_strobe_pin,
    input wire logic write_strobe_pin,
    input wire logic [1:0] slave_byte_select,
    input wire logic [7:0] port_data_lines_in,
    output logic [7:0] port_data_lines_out,
    output logic port_data_lines_oe_n
);

    // ****************************************
    // Configuration decode
    // ****************************************
    logic port_on;
    logic addressed_mode;
    apsp_pkg::apsp_irq_mode_t irq_mode_field;
    assign port_on = port_control_reg[`APSP_CTL_ON];
    assign addressed_mode = (port_mode_reg[`APSP_MODE_SEL_HI:`APSP_MODE_SEL_LO]
        == `APSP_MODE_ADDRESSED);
    assign irq_mode_field = apsp_pkg::apsp_irq_mode_t'(
        port_mode_reg[`APSP_MODE_IRQ_HI:`APSP_MODE_IRQ_LO]);
    logic active;
    assign active = port_on && addressed_mode;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    // Polarity applied before the first flop; a polarity change while
    // enabled may show as a strobe, hence configure while disabled.
    logic [2:0] cs_sync_q, rd_sync_q, wr_sync_q;
    logic [1:0] addr_s1_q, addr_s2_q;
    logic [7:0] din_s1_q, din_s2_q;
    logic cs_q, rd_q, wr_q;
    logic cs_pin_act, rd_pin_act, wr_pin_act;
    assign cs_pin_act = chip_select_pin ~^ port_control_reg[`APSP_CTL_CSP];
    assign rd_pin_act = read_strobe_pin ~^ port_control_reg[`APSP_CTL_READ_STROBE_POLARITY];
    assign wr_pin_act = write_strobe_pin ~^ port_control_reg[`APSP_CTL_WRITE_STROBE_POLARITY];

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cs_sync_q <= 3'h0;
            rd_sync_q <= 3'h0;
            wr_sync_q <= 3'h0;
        end else begin
            cs_sync_q <= {cs_sync_q[1:0], cs_pin_act};
            rd_sync_q <= {rd_sync_q[1:0], rd_pin_act};
            wr_sync_q <= {wr_sync_q[1:0], wr_pin_act};
        end
    end

    // A level counts once stages two and three agree
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cs_q <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            if (cs_sync_q[1] == cs_sync_q[2]) begin
                cs_q <= cs_sync_q[2];
            end
            if (rd_sync_q[1] == rd_sync_q[2]) begin
                rd_q <= rd_sync_q[2];
            end
            if (wr_sync_q[1] == wr_sync_q[2]) begin
                wr_q <= wr_sync_q[2];
            end
        end
    end

    // Address and data are stable while a strobe is held
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            addr_s1_q <= 2'h0;
            addr_s2_q <= 2'h0;
            din_s1_q <= 8'h00;
            din_s2_q <= 8'h00;
        end else begin
            addr_s1_q <= slave_byte_select;
            addr_s2_q <= addr_s1_q;
            din_s1_q <= port_data_lines_in;
            din_s2_q <= din_s1_q;
        end
    end

    // ****************************************
    // Strobe sequencing
    // ****************************************
    apsp_pkg::apsp_state_t state_q;
    logic rd_evt, wr_evt;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= apsp_pkg::APSP_IDLE;
        end else begin
            case (state_q)
                apsp_pkg::APSP_IDLE: begin
                    if (active && cs_q && rd_q) begin
                        state_q <= apsp_pkg::APSP_RD;
                    end else if (active && cs_q && wr_q) begin
                        state_q <= apsp_pkg::APSP_WR;
                    end
                end
                apsp_pkg::APSP_RD: begin
                    if (!rd_q || !cs_q) begin
                        state_q <= apsp_pkg::APSP_IDLE;
                    end
                end
                apsp_pkg::APSP_WR: begin
                    if (!wr_q || !cs_q) begin
                        state_q <= apsp_pkg::APSP_IDLE;
                    end
                end
                default: begin
                    state_q <= apsp_pkg::APSP_IDLE;
                end
            endcase
        end
    end
    // One pulse at the active edge of each strobe
    assign rd_evt = (state_q == apsp_pkg::APSP_IDLE) && active && cs_q && rd_q;
    assign wr_evt = (state_q == apsp_pkg::APSP_IDLE) && active && cs_q && wr_q
        && !rd_q;

    function automatic logic [3:0] apsp_onehot(input logic [1:0] sel);
        apsp_onehot = 4'h1 << sel;
    endfunction

    // ****************************************
    // Output buffers
    // ****************************************
    logic [7:0] out_mem_q [`APSP_BYTES];
    logic [3:0] out_empty_q;
    logic [3:0] rd_hit, ld_hit;
    assign rd_hit = rd_evt ? apsp_onehot(addr_s2_q) : 4'h0;
    assign ld_hit = sw_out_load ? apsp_onehot(sw_out_sel) : 4'h0;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < `APSP_BYTES; i++) begin
                out_mem_q[i] <= 8'h00;
            end
        end else if (sw_out_load) begin
            out_mem_q[sw_out_sel] <= sw_out_data;
        end
    end

    // Bus read wins over a load in the same cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            out_empty_q <= `APSP_OUT_EMPTY_RST;
        end else begin
            out_empty_q <= (out_empty_q & ~ld_hit) | rd_hit;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            out_underflow <= 1'b0;
        end else begin
            out_underflow <= |(rd_hit & out_empty_q);
        end
    end

    // Pins are driven from the raw pin levels, the byte one register late, so the master sees data
    // without waiting for the synchroniser.
    logic [7:0] drive_q;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            drive_q <= 8'h00;
        end else begin
            drive_q <= out_mem_q[slave_byte_select];
        end
    end
    assign port_data_lines_out = drive_q;
    assign port_data_lines_oe_n = !(active && cs_pin_act && rd_pin_act);

    // ****************************************
    // Input buffers
    // ****************************************
    logic [7:0] in_mem_q [`APSP_BYTES];
    logic [3:0] in_full_q;
    logic [3:0] wr_hit, clr_hit;
    logic pop;
    assign wr_hit = wr_evt ? apsp_onehot(addr_s2_q) : 4'h0;
    assign clr_hit = pop ? apsp_onehot(sw_in_sel) : 4'h0;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < `APSP_BYTES; i++) begin
                in_mem_q[i] <= 8'h00;
            end
        end else if (wr_evt && !in_full_q[addr_s2_q]) begin
            in_mem_q[addr_s2_q] <= din_s2_q;
        end
    end

    // Bus write wins over a software read in the same cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            in_full_q <= `APSP_IN_FULL_RST;
        end else begin
            in_full_q <= (in_full_q & ~clr_hit) | wr_hit;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            in_overflow <= 1'b0;
        end else begin
            in_overflow <= |(wr_hit & in_full_q);
        end
    end

    // ****************************************
    // Two-entry buffer for software reads
    // ****************************************
    logic [7:0] fifo_q [2];
    logic wp_q, rp_q;
    logic [1:0] cnt_q;
    logic push_out;
    assign sw_in_req_ready = (cnt_q != 2'h2);
    assign pop = sw_in_req && sw_in_req_ready;
    assign sw_in_valid = (cnt_q != 2'h0);
    assign push_out = sw_in_valid && sw_in_ready;
    assign sw_in_data = fifo_q[rp_q];

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            fifo_q[0] <= 8'h00;
            fifo_q[1] <= 8'h00;
            wp_q <= 1'b0;
        end else if (pop) begin
            fifo_q[wp_q] <= in_mem_q[sw_in_sel];
            wp_q <= !wp_q;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push_out) begin
                rp_q <= !rp_q;
            end
            cnt_q <= cnt_q + {1'b0, pop} - {1'b0, push_out};
        end
    end

    // ****************************************
    // Interrupt flag
    // ****************************************
    logic strobe_evt, irq_cause;
    assign strobe_evt = rd_evt || wr_evt;
    always_comb begin
        case (irq_mode_field)
            apsp_pkg::APSP_IRQ_EVERY: irq_cause = strobe_evt;
            apsp_pkg::APSP_IRQ_LAST: irq_cause = strobe_evt
                && (addr_s2_q == `APSP_LAST_BYTE);
            default: irq_cause = 1'b0;
        endcase
    end

    // Set wins over a clear arriving in the same cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            port_irq_flag <= 1'b0;
        end else if (irq_cause) begin
            port_irq_flag <= 1'b1;
        end else if (port_irq_clear) begin
            port_irq_flag <= 1'b0;
        end
    end
    assign port_irq = port_irq_flag && port_irq_enable;

    // ****************************************
    // Status outputs
    // ****************************************
    assign per_buffer_out_empty = out_empty_q;
    assign per_buffer_in_full = in_full_q;
    assign all_out_empty = &out_empty_q;
    assign all_in_full = &in_full_q;
    assign output_buffer_reg = {out_mem_q[3], out_mem_q[2], out_mem_q[1], out_mem_q[0]};
    assign input_buffer_reg = {in_mem_q[3], in_mem_q[2], in_mem_q[1], in_mem_q[0]};

endmodule

// [dv/apsp_port_sva.sv]
// Checker for the addressable parallel slave port.
// Assumes it is bound to apsp_port and sees only its ports.
module apsp_port_sva (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Configuration and software side
    input wire logic [15:0] port_control_reg,
    input wire logic [15:0] port_mode_reg,
    input wire logic port_irq_enable,
    input wire logic sw_out_load,
    input wire logic [1:0] sw_out_sel,
    input wire logic port_irq_clear,
    // Status
    input wire logic [3:0] per_buffer_out_empty,
    input wire logic all_out_empty,
    input wire logic out_underflow,
    input wire logic [3:0] per_buffer_in_full,
    input wire logic all_in_full,
    input wire logic in_overflow,
    input wire logic port_irq_flag,
    input wire logic port_irq,
    input wire logic [31:0] output_buffer_reg,
    // Pins
    input wire logic chip_select_pin,
    input wire logic read_strobe_pin,
    input wire logic [1:0] slave_byte_select,
    input wire logic [7:0] port_data_lines_out,
    input wire logic port_data_lines_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    property p_all_out; all_out_empty == &per_buffer_out_empty; endproperty
    a_all_out: assert property (p_all_out) else $error("aggregate empty off");
    property p_all_in; all_in_full == &per_buffer_in_full; endproperty
    a_all_in: assert property (p_all_in) else $error("aggregate full off");
    property p_irq; port_irq == (port_irq_flag && port_irq_enable); endproperty
    a_irq: assert property (p_irq) else $error("request gating off");
    property p_sticky; $fell(port_irq_flag) |-> $past(port_irq_clear); endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped alone");
    property p_flag_mode; $rose(port_irq_flag) |-> port_mode_reg[14:13] inside {2'h1, 2'h2};
    endproperty
    a_flag_mode: assert property (p_flag_mode) else $error("flag in quiet mode");
    property p_oe; !port_data_lines_oe_n |-> port_control_reg[15] && port_mode_reg[9:8] == 2'h0;
    endproperty
    a_oe: assert property (p_oe) else $error("drive while off");
    property p_oe_on; port_control_reg[15] && port_mode_reg[9:8] == 2'h0
        && (chip_select_pin ~^ port_control_reg[3]) && (read_strobe_pin ~^ port_control_reg[0])
        |-> !port_data_lines_oe_n; endproperty
    a_oe_on: assert property (p_oe_on) else $error("read not driven");
    // Needs a steady address, since the pin byte is registered one cycle late
    property p_rd_data; !port_data_lines_oe_n && $stable(slave_byte_select)
        && $stable(output_buffer_reg)
        |-> port_data_lines_out == output_buffer_reg[8 * slave_byte_select +: 8]; endproperty
    a_rd_data: assert property (p_rd_data) else $error("wrong byte driven");
    // Quiet read pins for six cycles keep a bus read from racing the load
    property p_load; port_data_lines_oe_n [*6] ##0 sw_out_load
        |=> !per_buffer_out_empty[$past(sw_out_sel)]; endproperty
    a_load: assert property (p_load) else $error("load kept empty");
    property p_uf; out_underflow |=> !out_underflow; endproperty
    a_uf: assert property (p_uf) else $error("underflow too long");
    c_uf: cover property (out_underflow);
    c_of: cover property (in_overflow);
    c_irq: cover property (port_irq);
endmodule

bind apsp_port apsp_port_sva u_sva (.*);

// [dv/apsp_host_model.sv]
// External parallel master driving the slave port pins.
// Assumes one transfer at a time, called from the bench.
module apsp_host_model (
    // Clock and polarity {select, write, read}, 1 = active high
    input wire logic clock,
    input wire logic [2:0] pol,
    // Pins
    output logic chip_select_pin,
    output logic read_strobe_pin,
    output logic write_strobe_pin,
    output logic [1:0] slave_byte_select,
    output logic [7:0] port_data_lines_in,
    input wire logic [7:0] port_data_lines_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic cs_a = 1'b0;
    logic rd_a = 1'b0;
    logic wr_a = 1'b0;
    assign chip_select_pin = cs_a ~^ pol[2];
    assign write_strobe_pin = wr_a ~^ pol[1];
    assign read_strobe_pin = rd_a ~^ pol[0];
    initial slave_byte_select = 2'h0;
    initial port_data_lines_in = 8'h5A;
    // ****************
    // Transfer
    // ****************
    task automatic xfer(input logic is_rd, input logic [1:0] adr, input logic [7:0] wd,
                        output logic [7:0] rdat);
        @(posedge clock);
        #1;
        cs_a = 1'b1;
        slave_byte_select = adr;
        port_data_lines_in = is_rd ? ~port_data_lines_in : wd;
        rd_a = is_rd;
        wr_a = !is_rd;
        repeat (6) @(posedge clock);
        #1;
        rdat = port_data_lines_out;
        cs_a = 1'b0;
        rd_a = 1'b0;
        wr_a = 1'b0;
        // Released lines must not keep the old value
        port_data_lines_in = ~port_data_lines_in;
        slave_byte_select = ~adr;
        repeat (4) @(posedge clock);
        #1;
    endtask
endmodule

// [dv/tb.sv]
// Self-checking bench for the addressable parallel slave port.
// Assumes the host model and the bound checker are compiled before it.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, arst_n = 1'b0, port_irq_enable = 1'b0, sw_out_load = 1'b0;
    logic sw_in_req = 1'b0, sw_in_ready = 1'b0, port_irq_clear = 1'b0;
    logic [15:0] port_control_reg = 16'h800B, port_mode_reg = 16'h2000;
    logic [1:0] sw_out_sel = 2'h0, sw_in_sel = 2'h0, slave_byte_select;
    logic [7:0] sw_out_data = 8'h00, sw_in_data, port_data_lines_out, port_data_lines_in, rdat;
    logic sw_in_req_ready, sw_in_valid, all_out_empty, out_underflow, all_in_full, in_overflow;
    logic port_irq_flag, port_irq, port_data_lines_oe_n, chip_select_pin, read_strobe_pin;
    logic write_strobe_pin;
    int uf_cnt = 0, of_cnt = 0, n0 = 0;
    logic [3:0] per_buffer_out_empty, per_buffer_in_full;
    logic [31:0] output_buffer_reg, input_buffer_reg;
    logic [2:0] pol;
    int miscompares = 0, checks_done = 0;
    assign pol = {port_control_reg[3], port_control_reg[1:0]};
    apsp_port uut (.*);
    apsp_host_model u_host (.*);
    initial forever #20 clock = ~clock;
    // Pulses last one cycle, so catch them here
    // Counted mid-cycle, where the registered pulses have settled
    always @(negedge clock) begin
        if (out_underflow === 1'b1) uf_cnt++;
        if (in_overflow === 1'b1) of_cnt++;
    end
    // ****************
    // Helpers
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (miscompares == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic clr;
        port_irq_clear = 1'b1;
        step(1);
        port_irq_clear = 1'b0;
    endtask
    // ****************
    // Scenarios
    // ****************
    task automatic t_write;
        for (int i = 0; i < 4; i++) begin
            chk(all_in_full, 1'b0);
            u_host.xfer(1'b0, i[1:0], 8'hA0 + i[7:0], rdat);
            chk(per_buffer_in_full[i], 1'b1);
            step(3);
            chk(port_irq_flag, 1'b1);
            clr;
        end
        chk(all_in_full, 1'b1);
        chk(input_buffer_reg, 32'hA3A2A1A0);
        chk(of_cnt, 0);
        n0 = of_cnt;
        u_host.xfer(1'b0, 2'h2, 8'h55, rdat);
        chk(of_cnt - n0, 1);
        chk(input_buffer_reg, 32'hA3A2A1A0);
        clr;
    endtask
    task automatic t_sw_in;
        sw_in_req = 1'b1;
        step(1);
        sw_in_sel = 2'h1;
        step(1);
        chk(sw_in_req_ready, 1'b0);
        sw_in_req = 1'b0;
        chk(per_buffer_in_full, 4'hC);
        sw_in_ready = 1'b1;
        chk(sw_in_data, 8'hA0);
        step(1);
        chk(sw_in_data, 8'hA1);
        sw_in_req = 1'b1;
        sw_in_sel = 2'h2;
        step(1);
        chk(sw_in_data, 8'hA2);
        sw_in_sel = 2'h3;
        step(1);
        chk(sw_in_data, 8'hA3);
        sw_in_req = 1'b0;
        step(1);
        chk(sw_in_valid, 1'b0);
        chk(per_buffer_in_full, 4'h0);
        sw_in_ready = 1'b0;
    endtask
    task automatic t_read;
        sw_out_load = 1'b1;
        for (int i = 0; i < 4; i++) begin
            sw_out_sel = i[1:0];
            sw_out_data = 8'hC0 + i[7:0];
            step(1);
        end
        sw_out_load = 1'b0;
        step(1);
        chk(per_buffer_out_empty, 4'h0);
        chk(output_buffer_reg, 32'hC3C2C1C0);
        port_mode_reg = 16'h4000;
        u_host.xfer(1'b1, 2'h0, 8'h00, rdat);
        chk(rdat, 8'hC0);
        chk(port_irq_flag, 1'b0);
        chk(per_buffer_out_empty, 4'h1);
        u_host.xfer(1'b1, 2'h3, 8'h00, rdat);
        chk(rdat, 8'hC3);
        chk(port_irq_flag, 1'b1);
        chk(port_irq, 1'b0);
        port_irq_enable = 1'b1;
        step(1);
        chk(port_irq, 1'b1);
        clr;
        chk(uf_cnt, 0);
        n0 = uf_cnt;
        u_host.xfer(1'b1, 2'h0, 8'h00, rdat);
        chk(uf_cnt - n0, 1);
        chk(all_out_empty, 1'b0);
        u_host.xfer(1'b1, 2'h1, 8'h00, rdat);
        u_host.xfer(1'b1, 2'h2, 8'h00, rdat);
        chk(all_out_empty, 1'b1);
        chk(port_irq_flag, 1'b0);
    endtask
    task automatic t_cfg;
        port_control_reg = 16'h000B;
        u_host.xfer(1'b0, 2'h1, 8'h22, rdat);
        chk(per_buffer_in_full, 4'h0);
        port_control_reg = 16'h800B;
        port_mode_reg = 16'h0100;
        u_host.xfer(1'b0, 2'h2, 8'h22, rdat);
        chk(per_buffer_in_full, 4'h0);
        // Swap polarity while off so the flip is not seen as a strobe
        port_control_reg = 16'h0000;
        port_mode_reg = 16'h2000;
        step(6);
        port_control_reg = 16'h8000;
        step(6);
        u_host.xfer(1'b0, 2'h3, 8'h33, rdat);
        chk(per_buffer_in_full, 4'h8);
        chk(input_buffer_reg[31:24], 8'h33);
        chk(port_irq_flag, 1'b1);
        // Interrupt mode 11 stays quiet
        clr;
        port_mode_reg = 16'h6000;
        u_host.xfer(1'b0, 2'h0, 8'h44, rdat);
        chk(per_buffer_in_full, 4'h9);
        chk(port_irq_flag, 1'b0);
    endtask
    initial begin
        repeat (16) @(posedge clock);
        #1;
        arst_n = 1'b1;
        step(1);
        chk({per_buffer_out_empty, per_buffer_in_full, port_irq_flag}, 9'h1E0);
        t_write;
        t_sw_in;
        t_read;
        t_cfg;
        end_of_test;
    end
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        end_of_test;
    end
endmodule
